// *** hw/pulse_timing_pkg.sv ***
/*
 * Shared constants and types for the pulse latency and window timers:
 * register offsets, reset values, field layouts, time-step tables and states.
 * Assumes a single 125 MHz system clock and an 8-bit register port.
 */
package pulse_timing_pkg;

    // system clock period and the finest time step (0.625 ms)
    localparam int CLK_PERIOD_NS = 8;
    localparam int STEP_BASE_NS = 625000;
    localparam int STEP_BASE_CYCLES = STEP_BASE_NS / CLK_PERIOD_NS;

    // counter widths
    localparam int BASE_CNT_W = 17;
    localparam int PRESCALE_W = 9;
    localparam int EXP_W = 4;
    localparam int FIELD_W = 8;

    // register offsets
    localparam logic [7:0] ADDR_TIME_LIMIT = 8'h26;
    localparam logic [7:0] ADDR_LATENCY = 8'h27;
    localparam logic [7:0] ADDR_WINDOW = 8'h28;
    localparam logic [7:0] ADDR_CONTROL = 8'h40;
    localparam logic [7:0] ADDR_STATUS = 8'h41;
    localparam logic [7:0] ADDR_MASK = 8'h42;
    localparam logic [7:0] ADDR_STATE = 8'h43;

    // values after reset
    localparam logic [7:0] RST_TIME_LIMIT = 8'h00;
    localparam logic [7:0] RST_LATENCY = 8'h00;
    localparam logic [7:0] RST_WINDOW = 8'h00;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [2:0] RST_EVENTS = 3'h0;
    localparam logic [7:0] RST_RDATA = 8'h00;

    // width-limit step exponents (step = 0.625 ms << exp), nibble per rate code,
    // rate code 0 in the low nibble; interval timers use exp + 1
    localparam logic [31:0] EXP_NORMAL_HPF1 = 32'h55554321;
    localparam logic [31:0] EXP_NORMAL_HPF0 = 32'h33332100;
    localparam logic [31:0] EXP_LOW_POWER_LOW_NOISE_MODE_HPF1 = 32'h77754321;
    localparam logic [31:0] EXP_LOW_POWER_LOW_NOISE_MODE_HPF0 = 32'h55532100;
    localparam logic [31:0] EXP_HIGH_RES_HPF1 = 32'h22222221;
    localparam logic [31:0] EXP_HIGH_RES_HPF0 = 32'h00000000;
    localparam logic [31:0] EXP_LOW_POWER_HPF1 = 32'h88754321;
    localparam logic [31:0] EXP_LOW_POWER_HPF0 = 32'h66643210;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_LOW_POWER_LOW_NOISE = 2'h1,
        MODE_HIGH_RES = 2'h2,
        MODE_LOW_POWER = 2'h3
    } power_mode_t;

    // control register layout, bit 7 reserved
    typedef struct packed {
        logic reserved;
        power_mode_t power_mode;
        logic [2:0] rate;
        logic highpass_enable;
        logic double_enable;
    } control_t;

    // event bits shared by status and mask
    typedef struct packed {
        logic window_expired;
        logic double_pulse;
        logic single_pulse;
    } event_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_FIRST = 5'b00010,
        ST_LATENCY = 5'b00100,
        ST_WINDOW = 5'b01000,
        ST_SECOND = 5'b10000
    } tap_state_t;

endpackage

// *** hw/pulse_step_gen.sv ***
/*
 * Time-step generator: turns the system clock into the width-limit step and
 * the latency/window step for the selected rate, power mode and filter.
 * Assumes the control fields come from registers on the same clock.
 */
`timescale 1ns/1ps
module pulse_step_gen
    import pulse_timing_pkg::*;
#(
    parameter int BASE_CYCLES = STEP_BASE_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // step selection
    input wire logic highpass_enable,
    input power_mode_t power_mode,
    input wire logic [2:0] rate,
    // step pulses
    output logic width_tick,
    output logic interval_tick
);

    logic [BASE_CNT_W-1:0] base_cnt;
    logic [PRESCALE_W-1:0] prescale;
    logic base_tick;
    logic [EXP_W-1:0] width_exp;
    logic [EXP_W-1:0] interval_exp;
    logic [PRESCALE_W-1:0] width_mask;
    logic [PRESCALE_W-1:0] interval_mask;

    // step exponent lookup for the width limit
    function automatic logic [EXP_W-1:0] step_exp(input logic hpf, input power_mode_t mode,
                                                  input logic [2:0] r);
        logic [31:0] row;
        row = 32'h00000000;
        case (mode)
            MODE_NORMAL: row = hpf ? EXP_NORMAL_HPF1 : EXP_NORMAL_HPF0;
            MODE_LOW_POWER_LOW_NOISE: row = hpf ? EXP_LOW_POWER_LOW_NOISE_MODE_HPF1 : EXP_LOW_POWER_LOW_NOISE_MODE_HPF0;
            MODE_HIGH_RES: row = hpf ? EXP_HIGH_RES_HPF1 : EXP_HIGH_RES_HPF0;
            default: row = hpf ? EXP_LOW_POWER_HPF1 : EXP_LOW_POWER_HPF0;
        endcase
        return row[{r, 2'b00} +: EXP_W];
    endfunction

    // latency and window share one step, twice the width-limit step
    always_comb begin
        width_exp = step_exp(highpass_enable, power_mode, rate);
        interval_exp = EXP_W'(width_exp + 4'h1);
        width_mask = PRESCALE_W'((9'h001 << width_exp) - 9'h001);
        interval_mask = PRESCALE_W'((9'h001 << interval_exp) - 9'h001);
    end

    assign base_tick = (base_cnt == BASE_CNT_W'(BASE_CYCLES - 1));

    // finest step counter
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            base_cnt <= '0;
        end else if (base_tick) begin
            base_cnt <= '0;
        end else begin
            base_cnt <= BASE_CNT_W'(base_cnt + 1'b1);
        end
    end

    // free-running prescaler; a mode change takes effect at the next step boundary
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            prescale <= '0;
        end else if (base_tick) begin
            prescale <= PRESCALE_W'(prescale + 1'b1);
        end
    end

    assign width_tick = base_tick && ((prescale & width_mask) == width_mask);
    assign interval_tick = base_tick && ((prescale & interval_mask) == interval_mask);

endmodule

// *** hw/pulse_countdown.sv ***
/*
 * Reloadable 8-bit step countdown: loaded at the start of an interval,
 * decremented once per step, signals the end when it reaches zero.
 * Assumes load and abort are single-cycle controls from the same clock.
 */
`timescale 1ns/1ps
module pulse_countdown
    import pulse_timing_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // control
    input wire logic load,
    input wire logic [FIELD_W-1:0] load_value,
    input wire logic abort,
    input wire logic step_tick,
    // status
    output logic active,
    output logic done
);

    logic [FIELD_W-1:0] count;

    // zero count ends the interval before any further step is taken
    assign done = active && (count == '0) && !load && !abort;

    // count and run flag
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            count <= '0;
            active <= 1'b0;
        end else if (load) begin
            count <= load_value;
            active <= 1'b1;
        end else if (abort || done) begin
            active <= 1'b0;
        end else if (active && step_tick) begin
            count <= FIELD_W'(count - 1'b1);
        end
    end

endmodule

// *** hw/pulse_latency_window_timers.sv ***
/*
 * Pulse latency and second-pulse window timing with the pulse width limit,
 * the register port and the event interrupt.
 * Assumes above_threshold comes from the threshold comparator on clk_sys
 * and that software uses one-cycle read and write strobes, never both at once.
 */
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps

// How it works
// - after a qualified first pulse, latency runs and new pulse starts are ignored
// - latency step follows rate, mode and filter; max is step times 255
// - in double mode the second start must fall in the window after latency
// - a second pulse counts only when narrower than the time limit
// - the second pulse may end after the window has expired
// - window step uses the latency step mapping
// - the longest window is step times 255, the full field
// - time limit bounds how long the signal stays above threshold
module pulse_latency_window_timers
    import pulse_timing_pkg::*;
#(
    parameter int BASE_CYCLES = STEP_BASE_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // comparator side
    input wire logic above_threshold,
    // detection results
    output logic single_pulse,
    output logic double_pulse,
    output logic latency_active,
    output logic window_active,
    // interrupt
    output logic irq
);

    // configuration registers
    logic [7:0] pulse_time_limit;
    logic [7:0] pulse_latency_time;
    logic [7:0] second_pulse_window_time;
    control_t control;
    event_t status;
    event_t mask;

    // state and helper signals
    tap_state_t state;
    tap_state_t next_state;
    logic above_d;
    logic pulse_rise;
    logic pulse_fall;
    logic width_tick;
    logic interval_tick;
    logic width_load;
    logic width_abort;
    logic width_active;
    logic width_done;
    logic lat_load;
    logic lat_done;
    logic win_load;
    logic win_abort;
    logic win_done;
    logic lat_running;
    logic win_running;
    event_t ev;
    event_t rd_clear;
    logic [7:0] next_rdata;

    // step ticks for the current rate and mode
    pulse_step_gen #(
        .BASE_CYCLES(BASE_CYCLES)
    ) u_step (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .highpass_enable(control.highpass_enable),
        .power_mode(control.power_mode),
        .rate(control.rate),
        .width_tick(width_tick),
        .interval_tick(interval_tick)
    );

    // width limit, counted in the finer step
    pulse_countdown u_width (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .load(width_load),
        .load_value(pulse_time_limit),
        .abort(width_abort),
        .step_tick(width_tick),
        .active(width_active),
        .done(width_done)
    );

    // latency interval
    pulse_countdown u_latency (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .load(lat_load),
        .load_value(pulse_latency_time),
        .abort(1'b0),
        .step_tick(interval_tick),
        .active(lat_running),
        .done(lat_done)
    );

    // second-pulse window
    pulse_countdown u_window (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .load(win_load),
        .load_value(second_pulse_window_time),
        .abort(win_abort),
        .step_tick(interval_tick),
        .active(win_running),
        .done(win_done)
    );

    // edge detection on the comparator level; it is on this clock already
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            above_d <= 1'b0;
        end else begin
            above_d <= above_threshold;
        end
    end

    assign pulse_rise = above_threshold && !above_d;
    assign pulse_fall = !above_threshold && above_d;

    // detection sequence
    always_comb begin
        next_state = state;
        width_load = 1'b0;
        width_abort = 1'b0;
        lat_load = 1'b0;
        win_load = 1'b0;
        win_abort = 1'b0;
        ev = '0;
        case (state)
            ST_IDLE: begin
                if (pulse_rise) begin
                    width_load = 1'b1;
                    next_state = ST_FIRST;
                end
            end
            ST_FIRST: begin
                if (width_done) begin
                    // stayed above too long: not a pulse, wait for a fresh start
                    next_state = ST_IDLE;
                end else if (pulse_fall) begin
                    width_abort = 1'b1;
                    ev.single_pulse = 1'b1;
                    lat_load = 1'b1;
                    next_state = ST_LATENCY;
                end
            end
            ST_LATENCY: begin
                // rising edges here are dropped on purpose
                if (lat_done) begin
                    if (control.double_enable) begin
                        win_load = 1'b1;
                        next_state = ST_WINDOW;
                    end else begin
                        next_state = ST_IDLE;
                    end
                end
            end
            ST_WINDOW: begin
                // a start in the very cycle the window ends still counts
                if (pulse_rise) begin
                    win_abort = 1'b1;
                    width_load = 1'b1;
                    next_state = ST_SECOND;
                end else if (win_done) begin
                    ev.window_expired = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            ST_SECOND: begin
                // only the start had to be inside the window
                if (width_done) begin
                    next_state = ST_IDLE;
                end else if (pulse_fall) begin
                    width_abort = 1'b1;
                    ev.double_pulse = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // one-cycle result pulses, registered
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            single_pulse <= 1'b0;
            double_pulse <= 1'b0;
        end else begin
            single_pulse <= ev.single_pulse;
            double_pulse <= ev.double_pulse;
        end
    end

    assign latency_active = lat_running;
    assign window_active = win_running;

    // configuration writes
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pulse_time_limit <= RST_TIME_LIMIT;
            pulse_latency_time <= RST_LATENCY;
            second_pulse_window_time <= RST_WINDOW;
            control <= control_t'(RST_CONTROL);
            mask <= event_t'(RST_EVENTS);
        end else if (reg_wr) begin
            if (reg_addr == ADDR_TIME_LIMIT) begin
                pulse_time_limit <= reg_wdata;
            end else if (reg_addr == ADDR_LATENCY) begin
                pulse_latency_time <= reg_wdata;
            end else if (reg_addr == ADDR_WINDOW) begin
                second_pulse_window_time <= reg_wdata;
            end else if (reg_addr == ADDR_CONTROL) begin
                control <= control_t'({1'b0, reg_wdata[6:0]});
            end else if (reg_addr == ADDR_MASK) begin
                mask <= event_t'(reg_wdata[2:0]);
            end
        end
    end

    // a status read clears what it returned
    assign rd_clear = (reg_rd && reg_addr == ADDR_STATUS) ? status : event_t'(RST_EVENTS);

    // sticky event bits; a new event in the clearing cycle survives
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            status <= event_t'(RST_EVENTS);
        end else begin
            status <= (status & ~rd_clear) | ev;
        end
    end

    // read data mux, unmapped offsets read zero
    always_comb begin
        next_rdata = 8'h00;
        if (reg_addr == ADDR_TIME_LIMIT) begin
            next_rdata = pulse_time_limit;
        end else if (reg_addr == ADDR_LATENCY) begin
            next_rdata = pulse_latency_time;
        end else if (reg_addr == ADDR_WINDOW) begin
            next_rdata = second_pulse_window_time;
        end else if (reg_addr == ADDR_CONTROL) begin
            next_rdata = control;
        end else if (reg_addr == ADDR_STATUS) begin
            next_rdata = {5'h00, status};
        end else if (reg_addr == ADDR_MASK) begin
            next_rdata = {5'h00, mask};
        end else if (reg_addr == ADDR_STATE) begin
            next_rdata = {5'h00, width_active, win_running, lat_running};
        end
    end

    // read data stand for the one cycle after the strobe only
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= RST_RDATA;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= RST_RDATA;
        end
    end

    // level interrupt while any unmasked event is pending
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((status & ~rd_clear) | ev) & mask);
        end
    end

endmodule

// *** bench/pulse_latency_window_timers_props.sv ***
/*
 * Port-level properties of the pulse latency and window timers.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
module pulse_latency_window_timers_props
    import pulse_timing_pkg::*;
#(
    parameter int BASE_CYCLES = STEP_BASE_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // detection side
    input wire logic above_threshold,
    input wire logic single_pulse,
    input wire logic double_pulse,
    input wire logic latency_active,
    input wire logic window_active,
    input wire logic irq
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    // widest run: 255 of the slowest interval steps, one spare step for the free prescaler
    localparam longint MAX_RUN = 64'd256 * BASE_CYCLES * 512;
    longint lat_run;
    longint win_run;

    // length of the current latency run
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            lat_run <= 0;
        end else begin
            lat_run <= latency_active ? lat_run + 1 : 0;
        end
    end

    // length of the current window run
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            win_run <= 0;
        end else begin
            win_run <= window_active ? win_run + 1 : 0;
        end
    end

    // a write to an interval register followed at once by a read of it
    sequence s_write_reg;
        reg_wr && (reg_addr == ADDR_LATENCY || reg_addr == ADDR_WINDOW);
    endsequence
    sequence s_read_back;
        reg_rd && reg_addr == $past(reg_addr);
    endsequence

    property p_interval_readback;
        s_write_reg ##1 s_read_back |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    property p_rdata_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    property p_single_after_fall;
        single_pulse |-> !$past(above_threshold)
            && ($past(above_threshold, 2) || $past(above_threshold, 3));
    endproperty
    property p_double_after_fall;
        double_pulse |-> !$past(above_threshold)
            && ($past(above_threshold, 2) || $past(above_threshold, 3));
    endproperty
    property p_result_one_cycle;
        (single_pulse || double_pulse) |=> !(single_pulse || double_pulse);
    endproperty
    property p_latency_follows_single;
        single_pulse |-> ##[0:2] latency_active;
    endproperty
    property p_quiet_in_latency;
        latency_active && $past(latency_active) |-> !single_pulse && !double_pulse;
    endproperty
    property p_window_after_latency;
        $rose(window_active) |-> $past(latency_active) || $past(latency_active, 2)
            || $past(latency_active, 3);
    endproperty
    property p_latency_bounded;
        lat_run <= MAX_RUN;
    endproperty
    property p_window_bounded;
        win_run <= MAX_RUN;
    endproperty
    // the interrupt rises only on an event or two cycles after a mask write strobe
    property p_irq_from_event;
        $rose(irq) |-> single_pulse || double_pulse || $fell(window_active)
            || $past(reg_wr, 2);
    endproperty

    a_interval_readback: assert property (p_interval_readback)
        else $error("interval register did not read back the written value");
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside a read answer");
    a_single_after_fall: assert property (p_single_after_fall)
        else $error("single result without a preceding falling edge");
    a_double_after_fall: assert property (p_double_after_fall)
        else $error("double result without a preceding falling edge");
    a_result_one_cycle: assert property (p_result_one_cycle)
        else $error("result pulse longer than one cycle");
    a_latency_follows_single: assert property (p_latency_follows_single)
        else $error("latency did not start after a first pulse");
    a_quiet_in_latency: assert property (p_quiet_in_latency)
        else $error("pulse result while latency runs");
    a_window_after_latency: assert property (p_window_after_latency)
        else $error("window started without a latency end");
    a_latency_bounded: assert property (p_latency_bounded)
        else $error("latency longer than the widest step times 255");
    a_window_bounded: assert property (p_window_bounded)
        else $error("window longer than the widest step times 255");
    a_irq_from_event: assert property (p_irq_from_event)
        else $error("interrupt rose without an event");
endmodule

bind pulse_latency_window_timers pulse_latency_window_timers_props #(
    .BASE_CYCLES(BASE_CYCLES)
) props_u (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .above_threshold(above_threshold), .single_pulse(single_pulse),
    .double_pulse(double_pulse), .latency_active(latency_active),
    .window_active(window_active), .irq(irq)
);

// *** bench/pulse_latency_window_timers_tb.sv ***
/*
 * Self-checking bench for the pulse latency and window timers.
 * Assumes a shortened step base and the bound property checker.
 */
`timescale 1ns/1ps
module pulse_latency_window_timers_tb
    import pulse_timing_pkg::*;
;
    // four cycles stand for the finest step to keep the run short
    localparam int BC = 4;
    localparam int LIMIT = 80000;
    typedef struct {
        logic [7:0] ctrl;
        logic [7:0] n;
        int k;
    } row_t;

    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic above_threshold = 1'b0;
    logic [7:0] reg_rdata;
    logic single_pulse;
    logic double_pulse;
    logic latency_active;
    logic window_active;
    logic irq;
    int err_count = 0;
    int checks_done = 0;
    int n_single = 0;
    int n_double = 0;
    int cycles = 0;
    int run [2] = '{0, 0};
    int len [2] = '{0, 0};
    // interval step in units of 0.625 ms for each control setting
    row_t rows [8] = '{
        '{8'h01, 8'h03, 2}, '{8'h03, 8'h03, 4}, '{8'h5D, 8'h03, 2}, '{8'h5F, 8'h03, 8},
        '{8'h7F, 8'h02, 512}, '{8'h7D, 8'h02, 128}, '{8'h37, 8'h02, 256},
        '{8'h01, 8'hFF, 2}
    };
    logic [7:0] ra [8] = '{ADDR_TIME_LIMIT, ADDR_LATENCY, ADDR_WINDOW, ADDR_CONTROL,
        ADDR_STATUS, ADDR_MASK, ADDR_STATE, 8'h10};

    pulse_latency_window_timers #(
        .BASE_CYCLES(BC)
    ) dut_u (
        .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .above_threshold(above_threshold), .single_pulse(single_pulse),
        .double_pulse(double_pulse), .latency_active(latency_active),
        .window_active(window_active), .irq(irq)
    );

    // 125 MHz clock
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // bus tasks are entered just after a rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1; // left high for a following write; rd and pulse drop it
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        check(reg_rdata, exp);
        @(posedge clk_sys);
    endtask

    task automatic pulse(input int w);
        reg_wr <= 1'b0;
        above_threshold <= 1'b1;
        repeat (w) @(posedge clk_sys);
        above_threshold <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask

    // wait until both interval timers are idle; the timeout guards a hang
    task automatic settle();
        @(negedge clk_sys);
        while ((latency_active | window_active) !== 1'b0) begin
            @(negedge clk_sys);
        end
        @(posedge clk_sys);
    endtask

    // event counts and run lengths, sampled away from the edge
    always @(negedge clk_sys) begin
        cycles++;
        n_single += (single_pulse === 1'b1);
        n_double += (double_pulse === 1'b1);
        for (int i = 0; i < 2; i++) begin
            if ((i ? window_active : latency_active) === 1'b1) begin
                run[i]++;
            end else if (run[i] != 0) begin
                len[i] = run[i];
                run[i] = 0;
            end
        end
        if (cycles == LIMIT) begin
            err_count++;
            end_sim();
        end
    end

    initial begin
        int s;
        int sv;
        int dv;
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        // reset values, an unmapped place included
        foreach (ra[i]) rd(ra[i], 8'h00);
        wr(ADDR_LATENCY, 8'h5A);
        rd(ADDR_LATENCY, 8'h5A);
        wr(ADDR_WINDOW, 8'hA5);
        rd(ADDR_WINDOW, 8'hA5);
        wr(ADDR_CONTROL, 8'hFF);
        rd(ADDR_CONTROL, 8'h7F);
        wr(8'h10, 8'hFF);
        rd(8'h10, 8'h00);
        wr(ADDR_STATE, 8'hFF);
        rd(ADDR_STATE, 8'h00);
        $display("test registers done");
        wr(ADDR_TIME_LIMIT, 8'h10);
        wr(ADDR_MASK, 8'h07);
        // each row: latency and window length for one step setting, then the interrupt
        foreach (rows[i]) begin
            wr(ADDR_LATENCY, rows[i].n);
            wr(ADDR_WINDOW, rows[i].n);
            wr(ADDR_CONTROL, rows[i].ctrl);
            s = rows[i].k * BC;
            sv = n_single;
            pulse(2);
            settle();
            check(n_single, sv + 1);
            check(len[0] > (int'(rows[i].n) - 1) * s && len[0] <= int'(rows[i].n) * s + 2, 1);
            check(len[1] > (int'(rows[i].n) - 1) * s && len[1] <= int'(rows[i].n) * s + 2, 1);
            check(irq, 1'b1);
            rd(ADDR_STATUS, 8'h05);
            repeat (2) @(negedge clk_sys);
            check(irq, 1'b0);
            @(posedge clk_sys);
        end
        $display("test step table done");
        // pulse inside latency ignored, second pulse outlasting the window accepted
        wr(ADDR_LATENCY, 8'h03);
        wr(ADDR_WINDOW, 8'h04);
        wr(ADDR_CONTROL, 8'h01);
        sv = n_single;
        dv = n_double;
        pulse(2);
        pulse(2);
        check(n_single, sv + 1);
        while (window_active !== 1'b1) @(negedge clk_sys);
        @(posedge clk_sys);
        pulse(40);
        check(n_double, dv + 1);
        settle();
        rd(ADDR_STATUS, 8'h03);
        rd(ADDR_STATUS, 8'h00);
        $display("test double pulse done");
        // second pulse wider than the limit is not a double
        pulse(2);
        while (window_active !== 1'b1) @(negedge clk_sys);
        @(posedge clk_sys);
        pulse(80);
        check(n_double, dv + 1);
        settle();
        $display("test wide second pulse done");
        // reset with both interval timers idle clears everything
        arst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        rd(ADDR_STATUS, 8'h00);
        rd(ADDR_WINDOW, 8'h00);
        // masked events and an overlong first pulse
        wr(ADDR_TIME_LIMIT, 8'h10);
        sv = n_single;
        pulse(80);
        check(n_single, sv);
        pulse(2);
        settle();
        check(n_single, sv + 1);
        check(irq, 1'b0);
        rd(ADDR_STATUS, 8'h01);
        $display("test mask and width done");
        end_sim();
    end
endmodule
